// ### src/tsp_serial_ports.sv
// How it works
// - Data write transmits; read returns receive register
// - Receive double-buffered; unread byte blocks a newer one
// - Mode field picks shift, 8-bit, 9-bit modes
// - Filter suppresses bad frames; zero in shift mode
// - Hardware sets done flags; software clears them
// - Reception start condition depends on mode
// - Shift mode: data on rx pin, clock on tx
// - Shift mode: start after 4, end at 36
// - 8-bit frame: start, eight data, stop
// - 8-bit transmit bits aligned to baud rollovers
// - Falling edge starts; majority of samples 7-9
// - 8-bit acceptance needs clear flag and stop
// - 9-bit frame carries programmable ninth bit
// - 9-bit transmit ends at eleventh rollover
// - 9-bit acceptance needs clear flag and ninth
// - Fixed 9-bit rate: 1/64, 1/32, 1/16
// - Dedicated timer: 8-bit reload, machine cycles
// - Run bit starts timer feeding its port
// - Window select maps timers onto shared addresses
// - Fast-count bits select clock counting; upper zero
// - Baud source priority: dedicated, timer2, timer1
// - Doubling bit doubles timer1 derived rate
//
// The APB interface to the registers and the placing of the registers are this design's own decisions.
`include "tsp_params.svh"
`timescale 1ns/1ps
`default_nettype none
module tsp_serial_ports #(
  parameter int PORTS = 3
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire tsp_pkg::tsp_apb_req_t apb_req,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic t1_ovf,
  input wire logic t2_ovf,
  input wire logic [PORTS-1:0] rxd_i,
  output tsp_pkg::tsp_pins_t [PORTS-1:0] pins
);
  // ==========================================================
  // Helpers
  // Timer window code to port index, 3 when none
  function automatic logic [1:0] win_port(input logic [2:0] w);
    case (w)
      3'h1: win_port = 2'h0;
      3'h2: win_port = 2'h1;
      3'h4: win_port = 2'h2;
      default: win_port = 2'h3;
    endcase
  endfunction
  // Byte address of a per-port register
  function automatic logic [7:0] port_addr(input logic [7:0] base, input int p);
    port_addr = base + 8'(p) * `TSP_PORT_STEP;
  endfunction

  // ==========================================================
  // Storage
  logic [7:0] ctrl [PORTS]; // Serial control per port
  logic [7:0] rx_data [PORTS]; // Receive holding register
  logic [2:0] win; // Timer window select
  logic [2:0] baud_run; // Dedicated timer run bits
  logic [2:0] fast; // Fast-count bits
  logic dbl; // Baud doubling
  logic quad; // Baud quad select
  logic [2:0] use_t2; // Timer2 selected per port
  logic [7:0] tm_rel [PORTS]; // Timer reload bytes
  logic [7:0] tm_cnt [PORTS]; // Timer count bytes
  logic [2:0] tm_ovf; // Overflow pulses
  logic [1:0] mc_div; // Machine cycle divider
  logic [1:0] pre; // Fixed-rate prescaler
  logic t1_half; // Timer1 halving toggle
  logic [PORTS-1:0] s1, s2, s3, lvl; // Pin synchronisers
  logic [PORTS-1:0] tick; // Oversample tick
  logic [3:0] div16 [PORTS]; // Bit-period phase
  logic [PORTS-1:0] tx_pend, tx_busy;
  logic [10:0] tx_sh [PORTS];
  logic [3:0] tx_left [PORTS];
  logic [PORTS-1:0] m0_busy, m0_rx;
  logic [3:0] m0_ph [PORTS];
  logic [3:0] m0_sub [PORTS];
  logic [7:0] m0_sh [PORTS];
  tsp_pkg::tsp_rx_state_t rx_st [PORTS];
  logic [3:0] rx_t16 [PORTS];
  logic [3:0] rx_bit [PORTS];
  logic [8:0] rx_sh [PORTS];
  logic [PORTS-1:0] smp_a, smp_b;
  // Combinational events
  logic wr;
  logic mc_en;
  logic [PORTS-1:0] wr_data, wr_ctrl, wrap, maj, ti_set, ri_set, rx_abort, rb8_new;
  logic [7:0] data_new [PORTS];
  tsp_pkg::tsp_mode_t mode [PORTS];

  // ==========================================================
  // APB slave
  assign wr = psel && penable && pready && apb_req.pwrite;
  // One wait-free access: pready rises in the access phase
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pready <= 1'b0;
    end else begin
      pready <= psel && !penable && !pready;
    end
  end
  // Read data and error latched at the setup edge
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      prdata <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else if (psel && !penable) begin
      prdata <= 32'h0000_0000;
      pslverr <= 1'b0;
      case (apb_req.paddr)
        `TSP_AUX_CTRL: prdata[7:0] <= {win, 1'b0, baud_run[2], 1'b0, baud_run[1:0]};
        `TSP_FAST_CNT: prdata[7:0] <= {5'h00, fast}; // Upper nibble zero
        `TSP_TM_RELOAD: prdata[7:0] <= (win_port(win) < 2'(PORTS)) ? tm_rel[win_port(win)] : 8'h00;
        `TSP_TM_COUNT: prdata[7:0] <= (win_port(win) < 2'(PORTS)) ? tm_cnt[win_port(win)] : 8'h00;
        `TSP_PWR_CTRL: prdata[7:0] <= {dbl, 7'h00};
        `TSP_BAUD_CFG: prdata[7:0] <= {4'h0, use_t2, quad};
        default: begin
          pslverr <= 1'b1;
          for (int p = 0; p < PORTS; p++) begin
            if (apb_req.paddr == port_addr(`TSP_DATA_BASE, p)) begin
              pslverr <= 1'b0;
              prdata[7:0] <= rx_data[p]; // Separate receive register
            end
            if (apb_req.paddr == port_addr(`TSP_CTRL_BASE, p)) begin
              pslverr <= 1'b0;
              prdata[7:0] <= ctrl[p];
            end
          end
        end
      endcase
    end
  end
  // Shared control registers
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      win <= 3'h0;
      baud_run <= 3'h0;
      fast <= 3'h0;
      dbl <= 1'b0;
      quad <= 1'b0;
      use_t2 <= 3'h0;
    end else if (wr) begin
      case (apb_req.paddr)
        `TSP_AUX_CTRL: begin
          win <= apb_req.pwdata[`TSP_F_WIN_HI:`TSP_F_WIN_LO];
          baud_run <= {apb_req.pwdata[`TSP_F_RUN2], apb_req.pwdata[`TSP_F_RUN1],
                       apb_req.pwdata[`TSP_F_RUN0]};
        end
        `TSP_FAST_CNT: fast <= apb_req.pwdata[2:0]; // Upper bits dropped
        `TSP_PWR_CTRL: dbl <= apb_req.pwdata[`TSP_F_DBL];
        `TSP_BAUD_CFG: begin
          quad <= apb_req.pwdata[`TSP_F_QUAD];
          use_t2 <= apb_req.pwdata[`TSP_F_T2_HI:`TSP_F_T2_LO];
        end
        default: begin
        end
      endcase
    end
  end

  // ==========================================================
  // Baud timing
  assign mc_en = (mc_div == `TSP_MC_LAST);
  // Machine cycle divider, fixed-rate prescaler, timer1 halving
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      mc_div <= 2'h0;
      pre <= 2'h0;
      t1_half <= 1'b0;
    end else begin
      mc_div <= mc_en ? 2'h0 : mc_div + 2'h1; // Three clocks per machine cycle
      pre <= pre + 2'h1;
      if (t1_ovf) begin
        t1_half <= !t1_half;
      end
    end
  end
  // Dedicated 8-bit auto-reload timers
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      tm_ovf <= 3'h0;
      for (int p = 0; p < PORTS; p++) begin
        tm_rel[p] <= 8'h00;
        tm_cnt[p] <= 8'h00;
      end
    end else begin
      for (int p = 0; p < PORTS; p++) begin
        tm_ovf[p] <= 1'b0;
        if (wr && apb_req.paddr == `TSP_TM_RELOAD && win_port(win) == 2'(p)) begin
          tm_rel[p] <= apb_req.pwdata[7:0];
        end
        if (wr && apb_req.paddr == `TSP_TM_COUNT && win_port(win) == 2'(p)) begin
          tm_cnt[p] <= apb_req.pwdata[7:0];
        end else if (baud_run[p] && (fast[p] || mc_en)) begin
          if (tm_cnt[p] == 8'hFF) begin
            tm_cnt[p] <= tm_rel[p]; // Reload with overflow pulse
            tm_ovf[p] <= 1'b1;
          end else begin
            tm_cnt[p] <= tm_cnt[p] + 8'h01;
          end
        end
      end
    end
  end
  // Oversample tick per port and mode
  always_comb begin
    for (int p = 0; p < PORTS; p++) begin
      mode[p] = tsp_pkg::tsp_mode_t'(ctrl[p][`TSP_F_MODE_HI:`TSP_F_MODE_LO]);
      if (mode[p] == tsp_pkg::TSP_UART9F) begin
        case ({quad, dbl})
          2'h0: tick[p] = (pre == 2'h3);
          2'h3: tick[p] = 1'b1;
          default: tick[p] = pre[0];
        endcase
      end else if (baud_run[p]) begin
        tick[p] = tm_ovf[p]; // Dedicated timer wins
      end else if (use_t2[p]) begin
        tick[p] = t2_ovf;
      end else begin
        tick[p] = t1_ovf && (dbl || t1_half); // Doubling on timer1 and fixed-rate mode only
      end
      wrap[p] = tick[p] && (div16[p] == `TSP_OS_LAST);
    end
  end
  // Bit-period phase counters
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      for (int p = 0; p < PORTS; p++) begin
        div16[p] <= 4'h0;
      end
    end else begin
      for (int p = 0; p < PORTS; p++) begin
        if (tick[p]) begin
          div16[p] <= div16[p] + 4'h1;
        end
      end
    end
  end

  // ==========================================================
  // Receive pin synchronisers: a level counts once stages 2 and 3 agree
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s1 <= '1;
      s2 <= '1;
      s3 <= '1;
      lvl <= '1;
    end else begin
      s1 <= rxd_i;
      s2 <= s1;
      s3 <= s2;
      for (int p = 0; p < PORTS; p++) begin
        if (s2[p] == s3[p]) begin
          lvl[p] <= s3[p];
        end
      end
    end
  end

  // ==========================================================
  // Event decode
  always_comb begin
    for (int p = 0; p < PORTS; p++) begin
      wr_data[p] = wr && apb_req.paddr == port_addr(`TSP_DATA_BASE, p);
      wr_ctrl[p] = wr && apb_req.paddr == port_addr(`TSP_CTRL_BASE, p);
      maj[p] = (smp_a[p] & smp_b[p]) | (smp_a[p] & lvl[p]) | (smp_b[p] & lvl[p]);
      ti_set[p] = (tx_busy[p] && wrap[p] && tx_left[p] == 4'h1)
        || (m0_busy[p] && !m0_rx[p] && m0_ph[p] == `TSP_M0_PH_LAST
            && m0_sub[p] == `TSP_M0_SUB_LAST);
      ri_set[p] = 1'b0;
      rx_abort[p] = 1'b0;
      rb8_new[p] = ctrl[p][`TSP_F_RB8];
      data_new[p] = rx_data[p];
      if (m0_busy[p] && m0_rx[p] && m0_ph[p] == `TSP_M0_PH_LAST
          && m0_sub[p] == `TSP_M0_SUB_LAST) begin
        ri_set[p] = 1'b1; // Shift-mode reception done
        data_new[p] = m0_sh[p];
      end else if (rx_st[p] == tsp_pkg::TSP_RX_FRAME && tick[p] && rx_t16[p] == `TSP_SMP_C) begin
        if (rx_bit[p] == 4'h0) begin
          rx_abort[p] = maj[p]; // False start bit
        end else if (mode[p] == tsp_pkg::TSP_UART8 && rx_bit[p] == `TSP_LAST_8) begin
          // Stop bit decides under the filter
          ri_set[p] = !ctrl[p][`TSP_F_RI] && (!ctrl[p][`TSP_F_FILT] || maj[p]);
          rb8_new[p] = ri_set[p] ? maj[p] : rb8_new[p];
          data_new[p] = ri_set[p] ? rx_sh[p][8:1] : rx_data[p];
        end else if (mode[p] != tsp_pkg::TSP_UART8 && rx_bit[p] == `TSP_LAST_9) begin
          // Ninth bit decides, stop ignored
          ri_set[p] = !ctrl[p][`TSP_F_RI] && (!ctrl[p][`TSP_F_FILT] || rx_sh[p][8]);
          rb8_new[p] = ri_set[p] ? rx_sh[p][8] : rb8_new[p];
          data_new[p] = ri_set[p] ? rx_sh[p][7:0] : rx_data[p];
        end
      end
    end
  end

  // ==========================================================
  // Serial control and receive holding registers
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      for (int p = 0; p < PORTS; p++) begin
        ctrl[p] <= `TSP_CTRL_RESET;
        rx_data[p] <= 8'h00;
      end
    end else begin
      for (int p = 0; p < PORTS; p++) begin
        if (wr_ctrl[p]) begin
          ctrl[p] <= apb_req.pwdata[7:0];
          if (apb_req.pwdata[`TSP_F_MODE_HI:`TSP_F_MODE_LO] == 2'h0) begin
            ctrl[p][`TSP_F_FILT] <= 1'b0; // Filter held low in shift mode
          end
        end
        if (ri_set[p]) begin
          ctrl[p][`TSP_F_RB8] <= rb8_new[p];
        end
        // Hardware set wins over a software clear
        ctrl[p][`TSP_F_TI] <= ti_set[p] || (wr_ctrl[p] ? apb_req.pwdata[`TSP_F_TI]
                                                       : ctrl[p][`TSP_F_TI]);
        ctrl[p][`TSP_F_RI] <= ri_set[p] || (wr_ctrl[p] ? apb_req.pwdata[`TSP_F_RI]
                                                       : ctrl[p][`TSP_F_RI]);
        rx_data[p] <= data_new[p]; // Updated only when a byte is accepted
      end
    end
  end

  // ==========================================================
  // Asynchronous transmitter
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      tx_pend <= '0;
      tx_busy <= '0;
      for (int p = 0; p < PORTS; p++) begin
        tx_sh[p] <= 11'h7FF;
        tx_left[p] <= 4'h0;
      end
    end else begin
      for (int p = 0; p < PORTS; p++) begin
        if (wr_data[p] && mode[p] != tsp_pkg::TSP_SHIFT) begin
          tx_pend[p] <= 1'b1; // Data write launches a frame
          tx_busy[p] <= 1'b0;
          if (mode[p] == tsp_pkg::TSP_UART8) begin
            tx_sh[p] <= {2'h3, apb_req.pwdata[7:0], 1'b0};
            tx_left[p] <= `TSP_BITS_8;
          end else begin
            tx_sh[p] <= {1'b1, ctrl[p][`TSP_F_TB8], apb_req.pwdata[7:0], 1'b0};
            tx_left[p] <= `TSP_BITS_9;
          end
        end else if (wrap[p] && tx_pend[p]) begin
          tx_pend[p] <= 1'b0; // Start bit begins on a rollover
          tx_busy[p] <= 1'b1;
        end else if (wrap[p] && tx_busy[p]) begin
          tx_sh[p] <= {1'b1, tx_sh[p][10:1]}; // LSB first
          tx_left[p] <= tx_left[p] - 4'h1;
          if (tx_left[p] == 4'h1) begin
            tx_busy[p] <= 1'b0;
          end
        end
      end
    end
  end

  // ==========================================================
  // Shift-register mode engine: 9 windows of 12 clocks
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      m0_busy <= '0;
      m0_rx <= '0;
      for (int p = 0; p < PORTS; p++) begin
        m0_ph[p] <= 4'h0;
        m0_sub[p] <= 4'h0;
        m0_sh[p] <= 8'h00;
      end
    end else begin
      for (int p = 0; p < PORTS; p++) begin
        if (wr_data[p] && mode[p] == tsp_pkg::TSP_SHIFT) begin
          m0_busy[p] <= 1'b1;
          m0_rx[p] <= 1'b0;
          m0_ph[p] <= 4'h0;
          m0_sub[p] <= 4'h0;
          m0_sh[p] <= apb_req.pwdata[7:0];
        end else if (!m0_busy[p] && mode[p] == tsp_pkg::TSP_SHIFT
                     && ctrl[p][`TSP_F_REN] && !ctrl[p][`TSP_F_RI]) begin
          m0_busy[p] <= 1'b1; // Receive enabled and flag clear
          m0_rx[p] <= 1'b1;
          m0_ph[p] <= 4'h0;
          m0_sub[p] <= 4'h0;
        end else if (m0_busy[p]) begin
          m0_sub[p] <= (m0_sub[p] == `TSP_M0_SUB_LAST) ? 4'h0 : m0_sub[p] + 4'h1;
          if (m0_sub[p] == `TSP_M0_SUB_LAST) begin
            m0_ph[p] <= m0_ph[p] + 4'h1; // Four machine cycles per window
            if (m0_ph[p] == `TSP_M0_PH_LAST) begin
              m0_busy[p] <= 1'b0; // Ends in machine cycle 36
            end
            if (!m0_rx[p] && m0_ph[p] != 4'h0) begin
              m0_sh[p] <= {1'b0, m0_sh[p][7:1]};
            end
          end
          if (m0_rx[p] && m0_ph[p] != 4'h0 && m0_sub[p] == `TSP_M0_SUB_RISE) begin
            m0_sh[p] <= {lvl[p], m0_sh[p][7:1]}; // Sampled at clock rise
          end
        end
      end
    end
  end

  // ==========================================================
  // Asynchronous receiver
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      smp_a <= '0;
      smp_b <= '0;
      for (int p = 0; p < PORTS; p++) begin
        rx_st[p] <= tsp_pkg::TSP_RX_IDLE;
        rx_t16[p] <= 4'h0;
        rx_bit[p] <= 4'h0;
        rx_sh[p] <= 9'h000;
      end
    end else begin
      for (int p = 0; p < PORTS; p++) begin
        case (rx_st[p])
          tsp_pkg::TSP_RX_IDLE: begin
            if (mode[p] != tsp_pkg::TSP_SHIFT && ctrl[p][`TSP_F_REN]
                && lvl[p] && !s2[p] && !s3[p]) begin
              rx_st[p] <= tsp_pkg::TSP_RX_FRAME; // Falling edge starts frame
              rx_t16[p] <= 4'h0;
              rx_bit[p] <= 4'h0;
            end
          end
          tsp_pkg::TSP_RX_FRAME: begin
            if (tick[p]) begin
              rx_t16[p] <= rx_t16[p] + 4'h1;
              if (rx_t16[p] == `TSP_SMP_A) begin
                smp_a[p] <= lvl[p];
              end
              if (rx_t16[p] == `TSP_SMP_B) begin
                smp_b[p] <= lvl[p];
              end
              if (rx_t16[p] == `TSP_SMP_C) begin
                if (rx_abort[p] || rx_bit[p] == ((mode[p] == tsp_pkg::TSP_UART8)
                    ? `TSP_LAST_8 : `TSP_LAST_9)) begin
                  rx_st[p] <= tsp_pkg::TSP_RX_IDLE;
                end else if (rx_bit[p] != 4'h0) begin
                  rx_sh[p] <= {maj[p], rx_sh[p][8:1]}; // LSB first
                end
              end
              if (rx_t16[p] == `TSP_OS_LAST) begin
                rx_bit[p] <= rx_bit[p] + 4'h1;
              end
            end
          end
          default: rx_st[p] <= tsp_pkg::TSP_RX_IDLE;
        endcase
      end
    end
  end

  // ==========================================================
  // Pin drive, registered
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pins <= '1;
      for (int p = 0; p < PORTS; p++) begin
        pins[p].rxd_oe <= 1'b0;
      end
    end else begin
      for (int p = 0; p < PORTS; p++) begin
        if (mode[p] == tsp_pkg::TSP_SHIFT) begin
          // Shift clock low in first half of each data window
          pins[p].txd <= !(m0_busy[p] && m0_ph[p] != 4'h0 && m0_sub[p] < `TSP_M0_SUB_RISE);
          pins[p].rxd_o <= m0_sh[p][0];
          pins[p].rxd_oe <= m0_busy[p] && !m0_rx[p] && m0_ph[p] != 4'h0;
        end else begin
          pins[p].txd <= tx_busy[p] ? tx_sh[p][0] : 1'b1;
          pins[p].rxd_o <= 1'b1;
          pins[p].rxd_oe <= 1'b0;
        end
      end
    end
  end

  // ==========================================================
  // Checks on port 0
  chk_tx_launch: assert property (@(posedge clk) disable iff (rst)
    (wr_data[0] && mode[0] != tsp_pkg::TSP_SHIFT) |=> tx_pend[0])
    else $error("data write did not launch a frame");
  chk_ti_at_end: assert property (@(posedge clk) disable iff (rst)
    $fell(tx_busy[0]) |-> ctrl[0][`TSP_F_TI])
    else $error("transmit flag not set at frame end");
  chk_m0_length: assert property (@(posedge clk) disable iff (rst)
    $rose(m0_busy[0]) |-> ##107 m0_busy[0] ##1 !m0_busy[0])
    else $error("shift transfer not 36 machine cycles");
  chk_start_bit: assert property (@(posedge clk) disable iff (rst)
    $rose(tx_busy[0]) |=> !pins[0].txd)
    else $error("start bit not low");
  chk_filter_zero: assert property (@(posedge clk) disable iff (rst)
    mode[0] == tsp_pkg::TSP_SHIFT && !$past(wr_ctrl[0]) |-> !ctrl[0][`TSP_F_FILT])
    else $error("filter set in shift mode");
  chk_fast_upper: assert property (@(posedge clk) disable iff (rst)
    $past(psel && !penable && apb_req.paddr == `TSP_FAST_CNT) |-> prdata[7:3] == 5'h00)
    else $error("fast-count upper bits not zero");
  chk_tm_reload: assert property (@(posedge clk) disable iff (rst)
    tm_ovf[0] && !$past(wr) |-> tm_cnt[0] == $past(tm_rel[0]))
    else $error("timer not reloaded on overflow");
  chk_ri_cause: assert property (@(posedge clk) disable iff (rst)
    $rose(ctrl[0][`TSP_F_RI]) |-> $past(ri_set[0]) || $past(wr_ctrl[0]))
    else $error("receive flag set without accepted frame");
  chk_tx_gap: assert property (@(posedge clk) disable iff (rst)
    $rose(tx_busy[0]) |-> $past(wrap[0]))
    else $error("frame start not on rollover");
endmodule
`default_nettype wire

// ### src/tsp_params.svh
`ifndef TSP_PARAMS_SVH
`define TSP_PARAMS_SVH
// ==========================================================
// Register byte addresses
`define TSP_DATA_BASE 8'h00
`define TSP_CTRL_BASE 8'h0C
`define TSP_AUX_CTRL 8'h18
`define TSP_FAST_CNT 8'h1C
`define TSP_TM_RELOAD 8'h20
`define TSP_TM_COUNT 8'h24
`define TSP_PWR_CTRL 8'h28
`define TSP_BAUD_CFG 8'h2C
`define TSP_PORT_STEP 8'h04
// ==========================================================
// Serial control field positions
`define TSP_F_MODE_HI 7
`define TSP_F_MODE_LO 6
`define TSP_F_FILT 5
`define TSP_F_REN 4
`define TSP_F_TB8 3
`define TSP_F_RB8 2
`define TSP_F_TI 1
`define TSP_F_RI 0
`define TSP_CTRL_RESET 8'h00
// Other control fields
`define TSP_F_WIN_HI 7
`define TSP_F_WIN_LO 5
`define TSP_F_RUN0 0
`define TSP_F_RUN1 1
`define TSP_F_RUN2 3
`define TSP_F_DBL 7
`define TSP_F_QUAD 0
`define TSP_F_T2_LO 1
`define TSP_F_T2_HI 3
// ==========================================================
// Timing counts in clock cycles or ticks
`define TSP_MC_LAST 2'h2
`define TSP_M0_SUB_LAST 4'hB
`define TSP_M0_SUB_RISE 4'h6
`define TSP_M0_PH_LAST 4'h8
`define TSP_OS_LAST 4'hF
`define TSP_SMP_A 4'h7
`define TSP_SMP_B 4'h8
`define TSP_SMP_C 4'h9
`define TSP_BITS_8 4'hA
`define TSP_BITS_9 4'hB
`define TSP_LAST_8 4'h9
`define TSP_LAST_9 4'hA
`endif

// ### src/tsp_pkg.sv
package tsp_pkg;
  // Operating modes of one port
  typedef enum logic [1:0] {TSP_SHIFT, TSP_UART8, TSP_UART9F, TSP_UART9T} tsp_mode_t;
  // Receiver sequencer states
  typedef enum logic {TSP_RX_IDLE, TSP_RX_FRAME} tsp_rx_state_t;
  // Pin drive of one port
  typedef struct packed {
    logic txd;
    logic rxd_o;
    logic rxd_oe;
  } tsp_pins_t;
  // APB request fields held by the master
  typedef struct packed {
    logic [7:0] paddr;
    logic pwrite;
    logic [31:0] pwdata;
  } tsp_apb_req_t;
endpackage

// ### testbench/tsp_remote_dev.sv
`timescale 1ns/1ps
`default_nettype none
// Remote serial device on the far side of the pins
module tsp_remote_dev (
  input wire logic clk,
  input wire logic rx_line,
  input wire logic sdat,
  output logic tx_line
);
  // Line idles high between frames
  initial begin
    tx_line = 1'b1;
  end
  // Sends a frame, least significant bit first
  task automatic send(input logic [10:0] f, input int n, input int bc);
    for (int i = 0; i < n; i++) begin
      tx_line <= f[i];
      repeat (bc) @(posedge clk);
    end
  endtask
  // Takes a frame at bit centres after the start edge
  task automatic recv(output logic [10:0] f, input int n, input int bc);
    f = '0;
    @(negedge rx_line);
    repeat (bc / 2) @(posedge clk);
    for (int i = 0; i < n; i++) begin
      f[i] = rx_line;
      repeat (bc) @(posedge clk);
    end
  endtask
  // Shift-mode partner, clocked by rx_line: drives on fall, samples on rise
  task automatic shift(input logic [7:0] dout, output logic [7:0] din);
    for (int i = 0; i < 8; i++) begin
      @(negedge rx_line);
      tx_line <= dout[i];
      @(posedge rx_line);
      din[i] = sdat;
    end
    tx_line <= 1'b1;
  endtask
endmodule
`default_nettype wire

// ### testbench/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  // ==========================================
  // Stimulus and observed signals
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  tsp_pkg::tsp_apb_req_t apb_req = '0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic line1;
  logic t1 = 1'b0;
  logic t2 = 1'b0;
  logic [7:0] sd;
  logic err;
  logic [31:0] rd;
  logic [10:0] fr;
  tsp_pkg::tsp_pins_t [2:0] pins;
  int n_fail = 0;
  int checked = 0;
  always #2.5 clk = ~clk;
  tsp_serial_ports tsp_serial_ports_i (.clk(clk), .rst(rst), .psel(psel), .penable(penable),
    .apb_req(apb_req), .prdata(prdata), .pready(pready), .pslverr(pslverr), .t1_ovf(t1),
    .t2_ovf(t2), .rxd_i({1'b1, line1, line1}), .pins(pins));
  // Open shift-data line reads high while port 0 does not drive it
  tsp_remote_dev tsp_remote_dev_i (.clk(clk), .rx_line(pins[0].txd),
    .sdat(pins[0].rxd_oe ? pins[0].rxd_o : 1'b1), .tx_line(line1));
  // One APB transfer; waits for pready at a rising edge
  task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    apb_req <= '{a, w, d};
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // Compares one value and counts it
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checked++;
    if (g !== e) begin
      n_fail++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask
  // Reset values, refused address, fast-count upper bits
  task automatic t_regs;
    bus(8'h0C, 1'b0, 32'h0);
    chk("ctrl0 reset", 32'h0, rd);
    bus(8'h40, 1'b0, 32'h0);
    chk("unmapped err", 32'h1, {31'h0, err});
    bus(8'h1C, 1'b1, 32'hFF);
    bus(8'h1C, 1'b0, 32'h0);
    chk("fast count", 32'h7, rd);
  endtask
  // Port 0 sends a 9-bit frame on its own fast timer
  task automatic t_tx9;
    bus(8'h18, 1'b1, 32'h20);
    bus(8'h20, 1'b1, 32'hF0);
    bus(8'h18, 1'b1, 32'h40);
    bus(8'h20, 1'b1, 32'hF0);
    bus(8'h20, 1'b0, 32'h0);
    chk("reload port1", 32'hF0, rd);
    bus(8'h18, 1'b1, 32'h03);
    bus(8'h0C, 1'b1, 32'hC8);
    bus(8'h00, 1'b1, 32'h96);
    tsp_remote_dev_i.recv(fr, 11, 256);
    chk("tx frame", {21'h0, 2'h3, 8'h96, 1'h0}, {21'h0, fr});
    repeat (512) @(posedge clk);
    bus(8'h0C, 1'b0, 32'h0);
    chk("tx done", 32'hCA, rd);
    bus(8'h0C, 1'b1, 32'hC8);
    bus(8'h0C, 1'b0, 32'h0);
    chk("tx clear", 32'hC8, rd);
  endtask
  // Port 1 takes 8-bit frames; a full buffer drops the next
  task automatic t_rx8;
    bus(8'h10, 1'b1, 32'h50);
    tsp_remote_dev_i.send({2'h1, 8'hA5, 1'h0}, 10, 256);
    repeat (256) @(posedge clk);
    bus(8'h10, 1'b0, 32'h0);
    chk("rx flags", 32'h55, rd);
    bus(8'h04, 1'b0, 32'h0);
    chk("rx data", 32'hA5, rd);
    tsp_remote_dev_i.send({2'h1, 8'h3C, 1'h0}, 10, 256);
    repeat (256) @(posedge clk);
    bus(8'h04, 1'b0, 32'h0);
    chk("rx dropped", 32'hA5, rd);
    bus(8'h10, 1'b1, 32'h50);
    tsp_remote_dev_i.send({2'h1, 8'h3C, 1'h0}, 10, 256);
    repeat (256) @(posedge clk);
    bus(8'h04, 1'b0, 32'h0);
    chk("rx second", 32'h3C, rd);
  endtask
  // Port 0 on fixed rate, then on timer2 and timer1 sources
  task automatic t_alt;
    bus(8'h18, 1'b1, 32'h02);
    bus(8'h0C, 1'b1, 32'h80);
    bus(8'h00, 1'b1, 32'h3C);
    tsp_remote_dev_i.recv(fr, 11, 64);
    chk("fixed rate", {21'h0, 2'h2, 8'h3C, 1'h0}, {21'h0, fr});
    t1 <= 1'b1;
    t2 <= 1'b1;
    bus(8'h2C, 1'b1, 32'h02);
    bus(8'h0C, 1'b1, 32'h40);
    bus(8'h00, 1'b1, 32'hA5);
    tsp_remote_dev_i.recv(fr, 10, 16);
    chk("timer2 rate", {21'h0, 2'h1, 8'hA5, 1'h0}, {21'h0, fr});
    bus(8'h2C, 1'b1, 32'h00);
    bus(8'h00, 1'b1, 32'h5A);
    tsp_remote_dev_i.recv(fr, 10, 32);
    chk("timer1 rate", {21'h0, 2'h1, 8'h5A, 1'h0}, {21'h0, fr});
    bus(8'h28, 1'b1, 32'h80);
    bus(8'h00, 1'b1, 32'h69);
    tsp_remote_dev_i.recv(fr, 10, 16);
    chk("doubled rate", {21'h0, 2'h1, 8'h69, 1'h0}, {21'h0, fr});
    t1 <= 1'b0;
    t2 <= 1'b0;
  endtask
  // Port 0 shift mode: eight bits out, then eight bits in
  task automatic t_shift;
    bus(8'h0C, 1'b1, 32'h00);
    bus(8'h00, 1'b1, 32'h5A);
    tsp_remote_dev_i.shift(8'hFF, sd);
    chk("shift out", 32'h5A, {24'h0, sd});
    repeat (16) @(posedge clk);
    bus(8'h0C, 1'b0, 32'h0);
    chk("shift tx done", 32'h02, rd);
    bus(8'h0C, 1'b1, 32'h10);
    tsp_remote_dev_i.shift(8'hC3, sd);
    repeat (16) @(posedge clk);
    bus(8'h0C, 1'b0, 32'h0);
    chk("shift rx done", 32'h11, rd);
    bus(8'h00, 1'b0, 32'h0);
    chk("shift in", 32'hC3, rd);
  endtask
  // Verdict and end of run
  task automatic test_done;
    $display("Checks %0d mismatches %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  // Main sequence
  initial begin
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    t_regs;
    t_tx9;
    t_rx8;
    t_alt;
    t_shift;
    test_done;
  end
  // Watchdog cuts a hang short
  initial begin
    repeat (40000) @(posedge clk);
    n_fail++;
    test_done;
  end
endmodule
`default_nettype wire
